// >>> inc/sjp_pkg.sv
// Constants and carrier types for the discoverable parameter table block
`default_nettype none
package sjp_pkg;
   // ---------------------------------------------------------------
   // Link command and table placement
   // ---------------------------------------------------------------
   localparam logic [7:0] SJP_OPC_READ_PARAMS = 8'h5A;
   localparam logic [23:0] SJP_TABLE_BASE = 24'h00_0030;
   localparam logic [23:0] SJP_TABLE_LAST = 24'h00_0053;
   localparam int SJP_ADDR_BYTES = 3;
   localparam logic [7:0] SJP_BLANK_BYTE = 8'hFF;
   localparam logic [31:0] SJP_BLANK_WORD = 32'hFFFFFFFF;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] SJP_OFS_BASIC_ERASE_WRITE_CAPS = 8'h30;
   localparam logic [7:0] SJP_OFS_ARRAY_DENSITY = 8'h34;
   localparam logic [7:0] SJP_OFS_QUAD_READ_DESCRIPTORS = 8'h38;
   localparam logic [7:0] SJP_OFS_DUAL_READ_DESCRIPTORS = 8'h3C;
   localparam logic [7:0] SJP_OFS_WIDE_MODE_SUPPORT = 8'h40;
   localparam logic [7:0] SJP_OFS_DUAL_WIDE_READ_DESCRIPTOR = 8'h44;
   localparam logic [7:0] SJP_OFS_QUAD_WIDE_READ_DESCRIPTOR = 8'h48;
   localparam logic [7:0] SJP_OFS_SECTOR_TYPES_ONE_TWO = 8'h4C;
   localparam logic [7:0] SJP_OFS_SECTOR_TYPES_THREE_FOUR = 8'h50;

   // ---------------------------------------------------------------
   // Fields of the first and fifth parameter words
   // ---------------------------------------------------------------
   localparam logic [1:0] SJP_ERASE_SIZE_4K = 2'b01;
   localparam logic SJP_WRITE_GRAN_BUFFER = 1'b1;
   localparam logic SJP_VOL_WREN_REQ = 1'b0;
   localparam logic SJP_VOL_WREN_OPC_SEL = 1'b0;
   localparam logic [2:0] SJP_FIRST_BYTE_UNUSED = 3'b111;
   localparam logic [7:0] SJP_ERASE_4K_OPCODE = 8'h20;
   localparam logic SJP_SUP_READ_112 = 1'b1;
   localparam logic [1:0] SJP_ADDR_BYTES_3_ONLY = 2'b00;
   localparam logic SJP_SUP_DTR = 1'b0;
   localparam logic SJP_SUP_READ_122 = 1'b1;
   localparam logic SJP_SUP_READ_144 = 1'b1;
   localparam logic SJP_SUP_READ_114 = 1'b1;
   localparam logic SJP_SUP_READ_222 = 1'b0;
   localparam logic SJP_SUP_READ_444 = 1'b0;
   localparam logic [2:0] SJP_WIDE_UNUSED = 3'b111;

   // ---------------------------------------------------------------
   // Read mode descriptors and sector types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] opcode;
      logic [2:0] mode_bits;
      logic [4:0] wait_states;
   } sjp_rd_desc_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] size_exp;
   } sjp_sector_t;

   localparam logic [4:0] SJP_NO_WAIT = 5'b00000;
   localparam logic [2:0] SJP_NO_MODE = 3'b000;
   localparam sjp_rd_desc_t SJP_DESC_144 = '{8'hEB, 3'b010, 5'b00100};
   localparam sjp_rd_desc_t SJP_DESC_114 = '{8'h6B, SJP_NO_MODE, 5'b01000};
   localparam sjp_rd_desc_t SJP_DESC_112 = '{8'h3B, SJP_NO_MODE, 5'b01000};
   localparam sjp_rd_desc_t SJP_DESC_122 = '{8'hBB, 3'b100, SJP_NO_WAIT};
   localparam sjp_rd_desc_t SJP_DESC_222 = '{8'hFF, SJP_NO_MODE, SJP_NO_WAIT};
   localparam sjp_rd_desc_t SJP_DESC_444 = '{8'hFF, SJP_NO_MODE, SJP_NO_WAIT};
   localparam sjp_sector_t SJP_SECTOR_1 = '{8'h20, 8'h0C};
   localparam sjp_sector_t SJP_SECTOR_2 = '{8'h52, 8'h0F};
   localparam sjp_sector_t SJP_SECTOR_3 = '{8'hD8, 8'h10};
   localparam sjp_sector_t SJP_SECTOR_4 = '{8'h81, 8'h08};

   // ---------------------------------------------------------------
   // Link phases and state carriers
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SJP_PH_CMD = 3'b000,
      SJP_PH_ADDR = 3'b001,
      SJP_PH_DUMMY = 3'b010,
      SJP_PH_DATA = 3'b011,
      SJP_PH_IGNORE = 3'b100
   } sjp_phase_t;

   typedef struct packed {
      sjp_phase_t phase;
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [7:0] sh_in;
      logic [23:0] addr;
      logic [7:0] sh_out;
      logic dens_s1;
      logic dens_s2;
   } sjp_link_t;

   typedef struct packed {
      logic [31:0] density;
      logic dens_rdy;
      logic tgl_s1;
      logic tgl_s2;
      logic tgl_s3;
      logic read_pulse;
      logic [15:0] read_count;
   } sjp_sys_t;

   localparam logic [2:0] SJP_LAST_BIT = 3'h7;
   localparam logic [1:0] SJP_LAST_ADDR_BYTE = 2'h2;
endpackage : sjp_pkg
`default_nettype wire

// >>> rtl/sjp_param_rom.sv
// Discoverable parameter table (30H..53H) served over the serial link
`default_nettype none

// Functional notes
// - Erase size field bits 1:0 read 01b, 4 KB erase supported.
// - Write granularity bit 2 reads 1, buffer of 64 bytes or more.
// - Volatile status write enable bits 3 and 4 both read 0.
// - Sector type 1: size exponent 0CH, erase opcode 20H.
// - Sector type 2: size exponent 0FH, erase opcode 52H.
// - Sector type 3: size exponent 10H, erase opcode D8H.
// - Sector type 4: size exponent 08H, erase opcode 81H.
// - Address byte count bits 18:17 read 00b, three-byte addressing only.
// - DTR clocking bit 19 reads 0.
// - 1-4-4 read supported: opcode EBH, wait 00100b, mode 010b.
// - 1-1-4 read supported: opcode 6BH, wait 01000b, mode 000b.
// - 1-1-2 read supported: wait 01000b, mode 000b.
// - 1-2-2 read supported: wait zero, mode 100b.
// - 2-2-2 read unsupported, opcode FFH, wait and mode zero.
// - 4-4-4 read unsupported, opcode FFH, wait and mode zero.
// - First byte bits 7:5 always read 111b, never alterable.
// - Sector size bytes are power-of-two exponents; zero means absent.
// - Zero wait field means no dummy clocks; 000b mode means none.
// - Read by 5AH, three address bytes, one dummy byte; out until deselect.
// - Table starts at byte address 30H as the header pointer says.
module sjp_param_rom #(
   parameter int ADDR_BYTES = sjp_pkg::SJP_ADDR_BYTES
) (
   // System side
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] density_word,
   output logic [15:0] read_count,
   output logic table_read,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   output logic so_oe_n
);
   import sjp_pkg::*;

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   // Table is only ever addressed with three bytes
   if (ADDR_BYTES != 3) begin : g_bad_addr
      $error("sjp_param_rom: only three address bytes are served");
   end

   // ---------------------------------------------------------------
   // Table contents
   // ---------------------------------------------------------------
   localparam logic [31:0] WORD_CAPS = {
      8'hFF,
      1'b1, SJP_SUP_READ_114, SJP_SUP_READ_144, SJP_SUP_READ_122,
      SJP_SUP_DTR,
      SJP_ADDR_BYTES_3_ONLY,
      SJP_SUP_READ_112,
      SJP_ERASE_4K_OPCODE,
      SJP_FIRST_BYTE_UNUSED,
      SJP_VOL_WREN_OPC_SEL, SJP_VOL_WREN_REQ,
      SJP_WRITE_GRAN_BUFFER,
      SJP_ERASE_SIZE_4K
   };
   // Zero wait/mode fields carry their "none" meaning unchanged
   localparam logic [31:0] WORD_QUAD = {SJP_DESC_114, SJP_DESC_144};
   localparam logic [31:0] WORD_DUAL = {SJP_DESC_122, SJP_DESC_112};
   localparam logic [31:0] WORD_WIDE = {
      24'hFFFFFF, SJP_WIDE_UNUSED, SJP_SUP_READ_444, SJP_WIDE_UNUSED, SJP_SUP_READ_222
   };
   localparam logic [31:0] WORD_DUAL_WIDE = {SJP_DESC_222, 16'hFFFF};
   localparam logic [31:0] WORD_QUAD_WIDE = {SJP_DESC_444, 16'hFFFF};
   // Exponent bytes, zero would mark a missing type
   localparam logic [31:0] WORD_SECT_12 = {SJP_SECTOR_2, SJP_SECTOR_1};
   localparam logic [31:0] WORD_SECT_34 = {SJP_SECTOR_4, SJP_SECTOR_3};

   function automatic logic [7:0] sjp_rom_byte(
      input logic [23:0] addr,
      input logic [31:0] density,
      input logic dens_ok
   );
      logic [31:0] word;
      logic [23:0] rel;
      word = SJP_BLANK_WORD;
      rel = addr - SJP_TABLE_BASE;
      unique case ({addr[7:2], 2'b00})
         SJP_OFS_BASIC_ERASE_WRITE_CAPS: word = WORD_CAPS;
         SJP_OFS_ARRAY_DENSITY: word = dens_ok ? density : SJP_BLANK_WORD;
         SJP_OFS_QUAD_READ_DESCRIPTORS: word = WORD_QUAD;
         SJP_OFS_DUAL_READ_DESCRIPTORS: word = WORD_DUAL;
         SJP_OFS_WIDE_MODE_SUPPORT: word = WORD_WIDE;
         SJP_OFS_DUAL_WIDE_READ_DESCRIPTOR: word = WORD_DUAL_WIDE;
         SJP_OFS_QUAD_WIDE_READ_DESCRIPTOR: word = WORD_QUAD_WIDE;
         SJP_OFS_SECTOR_TYPES_ONE_TWO: word = WORD_SECT_12;
         SJP_OFS_SECTOR_TYPES_THREE_FOUR: word = WORD_SECT_34;
         default: word = SJP_BLANK_WORD;
      endcase
      // Header and vendor areas live elsewhere; read blank here
      if (addr < SJP_TABLE_BASE || addr > SJP_TABLE_LAST || rel[23:6] != 18'h0) begin
         return SJP_BLANK_BYTE;
      end
      return word[8*addr[1:0] +: 8];
   endfunction : sjp_rom_byte

   // ---------------------------------------------------------------
   // System clock domain
   // ---------------------------------------------------------------
   sjp_sys_t s_q;
   sjp_sys_t s_d;
   logic served_tgl_q;

   always_comb begin
      s_d = s_q;
      s_d.read_pulse = 1'b0;
      // Density strap caught once after reset release, then frozen
      if (!s_q.dens_rdy) begin
         s_d.density = density_word;
         s_d.dens_rdy = 1'b1;
      end
      s_d.tgl_s1 = served_tgl_q;
      s_d.tgl_s2 = s_q.tgl_s1;
      s_d.tgl_s3 = s_q.tgl_s2;
      if (s_q.tgl_s2 != s_q.tgl_s3) begin
         s_d.read_pulse = 1'b1;
         s_d.read_count = s_q.read_count + 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign read_count = s_q.read_count;
   assign table_read = s_q.read_pulse;

   // ---------------------------------------------------------------
   // Link clock domain
   // ---------------------------------------------------------------
   // Deselect clears the link; sclk may stop between frames
   logic link_arst;
   sjp_link_t l_q;
   sjp_link_t l_d;
   logic so_q;
   logic so_oe_n_q;
   logic [7:0] sin;

   assign link_arst = rst | cs_n;

   always_comb begin
      l_d = l_q;
      sin = {l_q.sh_in[6:0], si};
      // Density word is stable before its ready level is seen here
      l_d.dens_s1 = s_q.dens_rdy;
      l_d.dens_s2 = l_q.dens_s1;
      l_d.bit_cnt = l_q.bit_cnt + 3'h1;
      unique case (l_q.phase)
         SJP_PH_CMD: begin
            l_d.sh_in = sin;
            if (l_q.bit_cnt == SJP_LAST_BIT) begin
               l_d.phase = (sin == SJP_OPC_READ_PARAMS) ? SJP_PH_ADDR : SJP_PH_IGNORE;
            end
         end
         SJP_PH_ADDR: begin
            l_d.addr = {l_q.addr[22:0], si};
            if (l_q.bit_cnt == SJP_LAST_BIT) begin
               l_d.byte_cnt = l_q.byte_cnt + 2'h1;
               if (l_q.byte_cnt == SJP_LAST_ADDR_BYTE) begin
                  l_d.byte_cnt = 2'h0;
                  l_d.phase = SJP_PH_DUMMY;
               end
            end
         end
         SJP_PH_DUMMY: begin
            if (l_q.bit_cnt == SJP_LAST_BIT) begin
               l_d.phase = SJP_PH_DATA;
               l_d.sh_out = sjp_rom_byte(l_q.addr, s_q.density, l_q.dens_s2);
            end
         end
         SJP_PH_DATA: begin
            // Streams bytes until deselect, address runs on
            if (l_q.bit_cnt == SJP_LAST_BIT) begin
               l_d.addr = l_q.addr + 24'h1;
               l_d.sh_out = sjp_rom_byte(l_q.addr + 24'h1, s_q.density, l_q.dens_s2);
            end else begin
               l_d.sh_out = {l_q.sh_out[6:0], 1'b0};
            end
         end
         SJP_PH_IGNORE: begin
            l_d.bit_cnt = l_q.bit_cnt;
         end
         default: begin
            l_d.phase = SJP_PH_IGNORE;
         end
      endcase
   end

   always_ff @(posedge sclk or posedge link_arst) begin
      if (link_arst) begin
         l_q <= '{phase: SJP_PH_CMD, default: '0};
      end else begin
         l_q <= l_d;
      end
   end

   // Frame counter event; survives deselect, so rst only
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         served_tgl_q <= 1'b0;
      end else if (!cs_n && l_q.phase == SJP_PH_DUMMY && l_q.bit_cnt == SJP_LAST_BIT) begin
         served_tgl_q <= ~served_tgl_q;
      end
   end

   // Output changes on the falling edge so the host samples it rising
   always_ff @(negedge sclk or posedge link_arst) begin
      if (link_arst) begin
         so_q <= 1'b0;
         so_oe_n_q <= 1'b1;
      end else begin
         so_q <= l_q.sh_out[7];
         so_oe_n_q <= (l_q.phase != SJP_PH_DATA);
      end
   end

   assign so = so_q;
   assign so_oe_n = so_oe_n_q;
endmodule : sjp_param_rom
`default_nettype wire

// >>> tb/sjp_host_model.sv
// Behavioural host controller on the serial link
`default_nettype none
module sjp_host_model (
   // Link outputs
   output var logic sclk,
   output var logic cs_n,
   output var logic si,
   // Link inputs
   input wire logic so,
   input wire logic so_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx [0:31];
   initial begin
      sclk = 1'b0;
      // Late deselect edge so frame tracking leaves its unknown start state
      cs_n = 1'b0;
      si = 1'b0;
      #2;
      cs_n = 1'b1;
   end
   // ---------------------------------------------------------------
   // Mode 0 frame; clock stands still between frames
   // ---------------------------------------------------------------
   task automatic frame(input logic [7:0] opc, input logic [23:0] adr, input int nbits,
                        input int half);
      logic [39:0] hdr;
      hdr = {opc, adr, 8'hA5};
      #13.3;
      cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         // Released input toggles so a stale level is never trusted
         si = (i < 40) ? hdr[39 - i] : ~si;
         #(half);
         sclk = 1'b1;
         // Undriven output reads high through its pull-up
         if (i >= 40) rx[(i - 40) / 8][7 - (i % 8)] = so_oe_n ? 1'b1 : so;
         #(half);
         sclk = 1'b0;
      end
      #(half);
      cs_n = 1'b1;
      si = ~si;
   endtask : frame
endmodule : sjp_host_model
`default_nettype wire

// >>> tb/sjp_param_rom_sva.sv
// Port checker for the discoverable parameter table block
`default_nettype none
module sjp_param_rom_sva
   import sjp_pkg::*;
#(
   parameter int ADDR_BYTES = 3
) (
   // System side
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] density_word,
   input wire logic [15:0] read_count,
   input wire logic table_read,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Frame tracking
   // ---------------------------------------------------------------
   localparam int DATA_EDGE = 16 + 8 * ADDR_BYTES;
   logic [5:0] edge_q;
   logic [7:0] opc_q;
   // Saturates far past the data phase, so long reads stay covered
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         edge_q <= 6'h00;
         opc_q <= 8'h00;
      end else begin
         if (edge_q != 6'h3F) edge_q <= edge_q + 6'h01;
         if (edge_q < 6'h08) opc_q <= {opc_q[6:0], si};
      end
   end
   sequence s_read_cmd;
      edge_q >= DATA_EDGE && opc_q == SJP_OPC_READ_PARAMS;
   endsequence
   sequence s_other_cmd;
      edge_q >= 6'h08 && opc_q != SJP_OPC_READ_PARAMS;
   endsequence
   property p_oe_on_read;
      @(posedge sclk) disable iff (rst || cs_n) s_read_cmd |-> !so_oe_n;
   endproperty
   property p_refuse;
      @(posedge sclk) disable iff (rst || cs_n) s_other_cmd |-> so_oe_n;
   endproperty
   property p_quiet_early;
      @(posedge sclk) disable iff (rst || cs_n) edge_q < DATA_EDGE |-> so_oe_n;
   endproperty
   property p_desel_oe;
      @(posedge clk) disable iff (rst) cs_n |-> so_oe_n;
   endproperty
   property p_desel_so;
      @(posedge clk) disable iff (rst) cs_n |-> !so;
   endproperty
   property p_pulse_one;
      @(posedge clk) disable iff (rst) table_read |=> !table_read;
   endproperty
   property p_count_inc;
      @(posedge clk) disable iff (rst) table_read |-> read_count == $past(read_count) + 16'h0001;
   endproperty
   property p_count_hold;
      @(posedge clk) disable iff (rst) !table_read |-> $stable(read_count);
   endproperty
   a_oe_on_read: assert property (p_oe_on_read) else $error("no output after read header");
   a_refuse: assert property (p_refuse) else $error("output driven on foreign opcode");
   a_quiet_early: assert property (p_quiet_early) else $error("output before data phase");
   a_desel_oe: assert property (p_desel_oe) else $error("output enabled while deselected");
   a_desel_so: assert property (p_desel_so) else $error("data line not low when deselected");
   a_pulse_one: assert property (p_pulse_one) else $error("read pulse longer than one cycle");
   a_count_inc: assert property (p_count_inc) else $error("count not stepped with pulse");
   a_count_hold: assert property (p_count_hold) else $error("count moved without pulse");
endmodule : sjp_param_rom_sva
bind sjp_param_rom sjp_param_rom_sva #(.ADDR_BYTES(ADDR_BYTES)) u_sva (
   .clk(clk), .rst(rst), .density_word(density_word), .read_count(read_count),
   .table_read(table_read), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
`default_nettype wire

// >>> tb/sjp_param_rom_tb_top.sv
// Self-checking bench for the discoverable parameter table
`default_nettype none
module sjp_param_rom_tb_top
   import sjp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 30000;
   localparam logic [7:0] TBL [0:35] = '{8'hE5, 8'h20, 8'hF1, 8'hFF, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h44, 8'hEB, 8'h08, 8'h6B, 8'h08, 8'h3B, 8'h80, 8'hBB, 8'hEE, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h0C, 8'h20, 8'h0F,
      8'h52, 8'h10, 8'hD8, 8'h08, 8'h81};
   logic clk = 1'b0;
   logic rst = 1'b0;
   logic [31:0] density_word = 32'h0;
   logic [31:0] dens;
   logic [15:0] exp_cnt = 16'h0;
   logic [15:0] read_count;
   logic table_read, sclk, cs_n, si, so, so_oe_n;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   int pulses = 0;
   sjp_param_rom DUT (.clk(clk), .rst(rst), .density_word(density_word), .read_count(read_count),
      .table_read(table_read), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
   sjp_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (rst === 1'b1) pulses = 0;
      else if (table_read === 1'b1) pulses++;
      if (cycles == LIMIT) begin
         fails++;
         print_verdict();
      end
   end
   // ---------------------------------------------------------------
   // Expectations and checks
   // ---------------------------------------------------------------
   function automatic logic [7:0] exp_byte(input logic [23:0] a, input logic [31:0] d);
      if (a < 24'h000030 || a > 24'h000053) return 8'hFF;
      if (a >= 24'h000034 && a <= 24'h000037) return d[8 * (a - 24'h000034) +: 8];
      return TBL[a - 24'h000030];
   endfunction : exp_byte
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", what, want, seen);
      end
   endtask : check
   task automatic read_cmp(input logic [23:0] adr, input int nb, input int half);
      host.frame(SJP_OPC_READ_PARAMS, adr, 40 + 8 * nb, half);
      exp_cnt++;
      for (int i = 0; i < nb; i++) begin
         check("table byte", {24'h0, host.rx[i]}, {24'h0, exp_byte(adr + 24'(i), dens)});
      end
      check("read count", {16'h0, read_count}, {16'h0, exp_cnt});
      check("pulse count", 32'(pulses), {16'h0, exp_cnt});
   endtask : read_cmp
   task automatic print_verdict();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   initial begin
      logic [7:0] op;
      logic [23:0] a;
      // Reset rises after time zero so every edge-triggered reset sees it
      #1;
      rst = 1'b1;
      void'($urandom(32'h4fe6));
      dens = $urandom;
      density_word = dens;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      read_cmp(24'h000030, 16, 40);
      read_cmp(24'h000040, 22, 40);
      // Random starts, last one from a slow host
      for (int k = 0; k < 4; k++) begin
         a = 24'h000028 + 24'($urandom % 48);
         read_cmp(a, 3, (k == 3) ? 120 : 40);
      end
      for (int k = 0; k < 3; k++) begin
         op = 8'($urandom);
         if (op == SJP_OPC_READ_PARAMS) op = 8'h5B;
         host.frame(op, 24'h000030, 56, 40);
         check("foreign opcode", {24'h0, host.rx[1]}, 32'hFF);
      end
      // Frame cut one edge before data
      host.frame(SJP_OPC_READ_PARAMS, 24'h000030, 39, 40);
      repeat (10) @(negedge clk);
      check("count after aborts", {16'h0, read_count}, {16'h0, exp_cnt});
      check("pulses after aborts", 32'(pulses), {16'h0, exp_cnt});
      rst = 1'b1;
      dens = $urandom;
      density_word = dens;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      exp_cnt = 16'h0;
      repeat (4) @(negedge clk);
      // Later changes must not reach the served word
      density_word = ~dens;
      read_cmp(24'h000034, 4, 40);
      print_verdict();
   end
endmodule : sjp_param_rom_tb_top
`default_nettype wire
